// >>> hw/fbs_defs.vh
// constants for the flow-through burst sram port
`ifndef FBS_DEFS_VH
`define FBS_DEFS_VH

`define FBS_ADDR_W 19
`define FBS_LANES 4
`define FBS_LANE_W 8
`define FBS_BURST_W 2

// interleaved when the strap is high, linear when low
`define FBS_MODE_INTERLEAVE 1'b1

// core clock period and clock-to-valid time, both in picoseconds
`define FBS_CLK_PERIOD_PS 10000
`define FBS_CDV_PS 6500
// longest time rounds down, but never below one cycle
`define FBS_CDV_CYC (((`FBS_CDV_PS / `FBS_CLK_PERIOD_PS) > 0) ? (`FBS_CDV_PS / `FBS_CLK_PERIOD_PS) : 1)

// sleep entry and exit, in core clock cycles
`define FBS_SLEEP_ENTER_CYC 2'd2
`define FBS_SLEEP_EXIT_CYC 2'd2
`define FBS_SLEEP_CNT_W 2

`endif

// >>> hw/fbs_burst_seq.v
// burst sequencer for the two low address bits
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"

module fbs_burst_seq (
    input wire [`FBS_BURST_W-1:0] i_start,
    input wire [`FBS_BURST_W-1:0] i_beat,
    input wire i_interleave,
    output wire [`FBS_BURST_W-1:0] o_low
);

    // both orders wrap inside the four-word group
    assign o_low = i_interleave ? (i_start ^ i_beat) : (i_start + i_beat);

endmodule

`default_nettype wire

// >>> hw/fbs_port.v
// device-side logic of a flow-through burst sram port
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"

module fbs_port #(
    parameter ADDR_W = `FBS_ADDR_W,
    parameter LANES = `FBS_LANES
)(
    input wire i_core_clk,
    input wire i_resetn,
    input wire i_clock_qualify_n,
    input wire i_chip_sel_first_n,
    input wire i_chip_sel_second,
    input wire i_chip_sel_third_n,
    input wire i_advance_or_load,
    input wire i_write_en_n,
    input wire [LANES-1:0] i_byte_lane_sel_n,
    input wire i_out_drive_en_n,
    input wire i_sleep_request,
    input wire i_burst_mode,
    input wire [ADDR_W-1:0] i_addr,
    input wire [LANES*`FBS_LANE_W-1:0] i_data,
    input wire [LANES-1:0] i_parity_lines,
    output reg [LANES*`FBS_LANE_W-1:0] o_data,
    output reg o_data_oe_n,
    output reg [LANES-1:0] o_parity_lines,
    output reg o_parity_oe_n,
    output reg o_sleeping
);

    localparam DW = LANES * `FBS_LANE_W;
    localparam SW = 9 + 2 * LANES + ADDR_W + DW;
    localparam DEPTH = 1 << ADDR_W;
    localparam BW = `FBS_BURST_W;

    localparam ST_AWAKE = 2'b00;
    localparam ST_ENTER = 2'b01;
    localparam ST_ASLEEP = 2'b10;
    localparam ST_EXIT = 2'b11;

    // every pin crosses two flops; one vector keeps all pins aligned
    wire [SW-1:0] pin_w;
    reg [SW-1:0] meta_r;
    reg [SW-1:0] sync_r;

    assign pin_w = {i_clock_qualify_n, i_chip_sel_first_n, i_chip_sel_second,
                    i_chip_sel_third_n, i_advance_or_load, i_write_en_n,
                    i_out_drive_en_n, i_sleep_request, i_burst_mode,
                    i_byte_lane_sel_n, i_addr, i_data, i_parity_lines};

    // all-zero reset value decodes as a deselect, so nothing starts
    always @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            meta_r <= {SW{1'b0}};
            sync_r <= {SW{1'b0}};
        end
        else
        begin
            meta_r <= pin_w;
            sync_r <= meta_r;
        end
    end

    wire s_qualify_n;
    wire s_sel_first_n;
    wire s_sel_second;
    wire s_sel_third_n;
    wire s_adv;
    wire s_write_en_n;
    wire s_drive_en_n;
    wire s_sleep;
    wire s_mode;
    wire [LANES-1:0] s_lane_sel_n;
    wire [ADDR_W-1:0] s_addr;
    wire [DW-1:0] s_data;
    wire [LANES-1:0] s_parity;

    assign {s_qualify_n, s_sel_first_n, s_sel_second, s_sel_third_n, s_adv,
            s_write_en_n, s_drive_en_n, s_sleep, s_mode, s_lane_sel_n, s_addr,
            s_data, s_parity} = sync_r;

    // memory array, parity kept beside the data lanes
    reg [DW-1:0] mem_data [0:DEPTH-1];
    reg [LANES-1:0] mem_par [0:DEPTH-1];

    // sleep sequencer
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [`FBS_SLEEP_CNT_W-1:0] cnt_r;
    reg [`FBS_SLEEP_CNT_W-1:0] cnt_nxt;

    always @*
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_AWAKE:
            begin
                if (s_sleep)
                begin
                    st_nxt = ST_ENTER;
                    cnt_nxt = `FBS_SLEEP_ENTER_CYC - 2'd1;
                end
            end
            ST_ENTER:
            begin
                if (cnt_r == {`FBS_SLEEP_CNT_W{1'b0}})
                    st_nxt = ST_ASLEEP;
                else
                    cnt_nxt = cnt_r - 2'd1;
            end
            ST_ASLEEP:
            begin
                if (!s_sleep)
                begin
                    st_nxt = ST_EXIT;
                    cnt_nxt = `FBS_SLEEP_EXIT_CYC - 2'd1;
                end
            end
            ST_EXIT:
            begin
                if (cnt_r == {`FBS_SLEEP_CNT_W{1'b0}})
                    st_nxt = ST_AWAKE;
                else
                    cnt_nxt = cnt_r - 2'd1;
            end
            default:
            begin
                st_nxt = ST_AWAKE;
                cnt_nxt = {`FBS_SLEEP_CNT_W{1'b0}};
            end
        endcase
    end

    // operation state
    reg act_r;
    reg act_nxt;
    reg wr_r;
    reg wr_nxt;
    reg [ADDR_W-1:0] base_r;
    reg [ADDR_W-1:0] base_nxt;
    reg [BW-1:0] beat_r;
    reg [BW-1:0] beat_nxt;
    reg [ADDR_W-1:0] addr_r;
    reg [LANES-1:0] lanes_r;
    reg wpend_r;

    wire awake;
    wire go;
    wire sel_all;
    wire [BW-1:0] low_w;
    wire [ADDR_W-1:0] addr_nxt;

    assign awake = (st_r == ST_AWAKE);
    assign go = awake & ~s_qualify_n;
    assign sel_all = ~s_sel_first_n & s_sel_second & ~s_sel_third_n;

    always @*
    begin
        act_nxt = act_r;
        wr_nxt = wr_r;
        base_nxt = base_r;
        beat_nxt = beat_r;
        if (!awake)
        begin
            act_nxt = 1'b0;
        end
        else if (go)
        begin
            if (!s_adv)
            begin
                act_nxt = sel_all;
                if (sel_all)
                begin
                    wr_nxt = ~s_write_en_n;
                    base_nxt = s_addr;
                    beat_nxt = {BW{1'b0}};
                end
            end
            else
            begin
                beat_nxt = beat_r + {{(BW-1){1'b0}}, 1'b1};
            end
        end
    end

    fbs_burst_seq u_seq (
        .i_start(base_nxt[BW-1:0]),
        .i_beat(beat_nxt),
        .i_interleave(s_mode == `FBS_MODE_INTERLEAVE),
        .o_low(low_w)
    );

    assign addr_nxt = {base_nxt[ADDR_W-1:BW], low_w};

    // merge of the incoming write word into the stored word
    reg [DW-1:0] wr_data;
    reg [LANES-1:0] wr_par;
    integer i;

    always @*
    begin
        wr_data = mem_data[addr_r];
        wr_par = mem_par[addr_r];
        for (i = 0; i < LANES; i = i + 1)
        begin
            if (!lanes_r[i])
            begin
                wr_data[i*`FBS_LANE_W +: `FBS_LANE_W] = s_data[i*`FBS_LANE_W +: `FBS_LANE_W];
                wr_par[i] = s_parity[i];
            end
        end
    end

    wire wr_now;
    wire rd_load;
    wire drive_nxt;

    // write completes on the first unstalled edge after its command, and is dropped if sleep entry starts first
    assign wr_now = wpend_r & go & ~(&lanes_r);
    assign rd_load = go & act_nxt & ~wr_nxt;
    // bus driven only for a live read; writes, deselects and sleep release it
    assign drive_nxt = (st_nxt == ST_AWAKE) & act_nxt & ~wr_nxt & ~s_drive_en_n;

    always @(posedge i_core_clk)
    begin
        if (wr_now)
        begin
            mem_data[addr_r] <= wr_data;
            mem_par[addr_r] <= wr_par;
        end
    end

    always @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            st_r <= ST_AWAKE;
            cnt_r <= {`FBS_SLEEP_CNT_W{1'b0}};
            act_r <= 1'b0;
            wr_r <= 1'b0;
            base_r <= {ADDR_W{1'b0}};
            beat_r <= {BW{1'b0}};
            addr_r <= {ADDR_W{1'b0}};
            lanes_r <= {LANES{1'b1}};
            wpend_r <= 1'b0;
            o_data <= {DW{1'b0}};
            o_parity_lines <= {LANES{1'b0}};
            o_data_oe_n <= 1'b1;
            o_parity_oe_n <= 1'b1;
            o_sleeping <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            wr_r <= wr_nxt;
            base_r <= base_nxt;
            beat_r <= beat_nxt;
            o_sleeping <= (st_nxt != ST_AWAKE);
            o_data_oe_n <= ~drive_nxt;
            o_parity_oe_n <= ~drive_nxt;
            if (!awake)
            begin
                wpend_r <= 1'b0;
            end
            else if (go)
            begin
                addr_r <= addr_nxt;
                wpend_r <= act_nxt & wr_nxt;
                if (act_nxt & wr_nxt)
                    lanes_r <= s_lane_sel_n;
                if (rd_load)
                begin
                    // forward a write landing on this same edge to the same word
                    if (wr_now && addr_r == addr_nxt)
                    begin
                        o_data <= wr_data;
                        o_parity_lines <= wr_par;
                    end
                    else
                    begin
                        o_data <= mem_data[addr_nxt];
                        o_parity_lines <= mem_par[addr_nxt];
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> sim/fbs_port_assertions.sv
// pin-level assertions for the sram port
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"
module fbs_port_assertions #(
    parameter LANES = `FBS_LANES
)(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clock_qualify_n,
    input wire logic i_chip_sel_first_n,
    input wire logic i_advance_or_load,
    input wire logic i_write_en_n,
    input wire logic i_out_drive_en_n,
    input wire logic i_sleep_request,
    input wire logic [LANES*`FBS_LANE_W-1:0] o_data,
    input wire logic o_data_oe_n,
    input wire logic o_parity_oe_n,
    input wire logic o_sleeping
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // every input crosses a two-flop sync, so causes are held four edges
    reset_float_a: assert property ($rose(i_resetn) |-> o_data_oe_n && o_parity_oe_n)
        else $error("bus driven right after reset");
    oe_follow_a: assert property (i_out_drive_en_n [*4] |=> o_data_oe_n)
        else $error("data driven with output enable high");
    stall_hold_a: assert property (i_clock_qualify_n [*4] |=> $stable(o_data))
        else $error("read word changed during stall");
    desel_float_a: assert property ((i_chip_sel_first_n && !i_advance_or_load
        && !i_clock_qualify_n) [*4] |=> o_data_oe_n)
        else $error("bus driven while deselected");
    write_float_a: assert property ((!i_write_en_n && !i_advance_or_load
        && !i_clock_qualify_n) [*4] |=> o_data_oe_n && o_parity_oe_n)
        else $error("bus driven in write data phase");
    sleep_enter_a: assert property (i_sleep_request [*4] |=> o_sleeping)
        else $error("sleep not entered");
    sleep_exit_a: assert property ($fell(o_sleeping) |-> !$past(i_sleep_request, 3))
        else $error("sleep left too early");
    sleep_float_a: assert property (o_sleeping && $past(o_sleeping) |-> o_data_oe_n)
        else $error("bus driven while asleep");
endmodule
bind fbs_port fbs_port_assertions #(.LANES(LANES)) i_chk (
    .i_core_clk, .i_resetn, .i_clock_qualify_n, .i_chip_sel_first_n, .i_advance_or_load,
    .i_write_en_n, .i_out_drive_en_n, .i_sleep_request, .o_data, .o_data_oe_n,
    .o_parity_oe_n, .o_sleeping
);
`default_nettype wire

// >>> sim/fbs_ctrl_model.sv
// behavioural memory controller driving the sram port pins
`timescale 1ns/1ps
`default_nettype none
module fbs_ctrl_model (
    input wire logic i_clk,
    input wire logic [35:0] i_q,
    input wire logic i_q_oe_n,
    output var logic o_qn,
    output var logic o_cs1_n,
    output var logic o_cs2,
    output var logic o_cs3_n,
    output var logic o_adv,
    output var logic o_we_n,
    output var logic [3:0] o_ln,
    output var logic o_oe_n,
    output var logic o_zz,
    output var logic o_mode,
    output var logic [18:0] o_a,
    output wire logic [35:0] o_d
);
    logic [35:0] wd, pw, last;
    logic drv, pdrv;
    initial
    begin
        {o_qn, o_cs1_n, o_cs2, o_cs3_n, o_adv, o_we_n, o_oe_n, o_zz, o_mode} = 9'h068;
        {o_ln, o_a, wd, pw, last, drv, pdrv} = {4'hf, 129'h0};
    end
    // a released bus toggles so a stale word can never pass for read data;
    // an unknown enable counts as released so the toggle starts from a known word
    assign o_d = (i_q_oe_n === 1'b0) ? i_q : drv ? wd : ~last;
    always @(posedge i_clk)
    begin
        {drv, wd} <= {pdrv, pw};
        last <= o_d;
    end
    task beat(input logic adv, sel, we, wr, input logic [3:0] ln,
        input logic [18:0] a, input logic [35:0] w);
        @(posedge i_clk);
        {o_adv, o_cs1_n, o_cs2, o_cs3_n, o_we_n, o_ln, o_a} <= {adv, !sel, sel, !sel, we, ln, a};
        {pdrv, pw} <= {wr, w};
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_flow_through_burst_sram_port.sv
// testbench for the flow-through burst sram port
`timescale 1ns/1ps
`default_nettype none
module tb_flow_through_burst_sram_port;
    localparam logic [18:0] BASE = 19'h5a3c4;
    logic clk, rst_n;
    logic [35:0] mem [4];
    int n_mismatch, check_count;
    wire qn, cs1_n, cs2, cs3_n, adv, we_n, oe_n, zz, mode, q_oe, p_oe, slp;
    wire [3:0] ln, qp;
    wire [18:0] a;
    wire [35:0] d;
    wire [31:0] q;
    fbs_port i_dut (.i_core_clk(clk), .i_resetn(rst_n), .i_clock_qualify_n(qn),
        .i_chip_sel_first_n(cs1_n), .i_chip_sel_second(cs2), .i_chip_sel_third_n(cs3_n),
        .i_advance_or_load(adv), .i_write_en_n(we_n), .i_byte_lane_sel_n(ln),
        .i_out_drive_en_n(oe_n), .i_sleep_request(zz), .i_burst_mode(mode), .i_addr(a),
        .i_data(d[31:0]), .i_parity_lines(d[35:32]), .o_data(q), .o_data_oe_n(q_oe),
        .o_parity_lines(qp), .o_parity_oe_n(p_oe), .o_sleeping(slp));
    fbs_ctrl_model i_ctrl (.i_clk(clk), .i_q({qp, q}), .i_q_oe_n(q_oe), .o_qn(qn),
        .o_cs1_n(cs1_n), .o_cs2(cs2), .o_cs3_n(cs3_n), .o_adv(adv), .o_we_n(we_n),
        .o_ln(ln), .o_oe_n(oe_n), .o_zz(zz), .o_mode(mode), .o_a(a), .o_d(d));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    function logic [35:0] word(input int l);
        return {l[3:0] ^ 4'h9, {4{2'b10, l[1:0], 4'h5}}};
    endfunction
    // bounded wait for sleep flag (sel high) or data enable (sel low)
    task wt(input logic sel, input logic v);
        int k;
        k = 0;
        while ((sel ? slp : q_oe) !== v && k < 12)
        begin
            @(negedge clk);
            k++;
        end
        chk((sel ? slp : q_oe) === v, "wait ran out");
        if ((sel ? slp : q_oe) !== v)
            complete_run;
    endtask
    task ds;
        i_ctrl.beat(0, 0, 1, 0, 4'hf, 0, 0);
    endtask
    task wr(input logic ad, input logic [1:0] s, input logic [3:0] l, input logic [35:0] w);
        logic [35:0] k;
        k = {~l, {8{~l[3]}}, {8{~l[2]}}, {8{~l[1]}}, {8{~l[0]}}};
        i_ctrl.beat(ad, !ad, ad, 1, l, ad ? ~BASE : {BASE[18:2], s}, w);
        mem[s] = (mem[s] & ~k) | (w & k);
    endtask
    task rd(input logic [1:0] s, input logic m, input int n, input int st);
        int i, r, b;
        logic [1:0] j;
        repeat (4) ds;
        i_ctrl.o_mode <= m;
        fork
            begin
                i_ctrl.beat(0, 1, 1, 0, 4'hf, {BASE[18:2], s}, 0);
                // own loop variable: the checking branch runs at the same time
                for (b = 1; b < n; b++)
                    if (b == 2 && st > 0)
                    begin
                        @(posedge clk) i_ctrl.o_qn <= 1'b1;
                        repeat (st - 1) @(posedge clk);
                        @(posedge clk) i_ctrl.o_qn <= 1'b0;
                    end
                    else
                        i_ctrl.beat(1, 0, 1, 0, 4'hf, ~BASE, 0);
                ds;
            end
            begin
                wt(1'b0, 1'b0);
                for (i = 0; i < n; i++)
                    for (r = 0; r <= (i == 1 ? st : 0); r++)
                    begin
                        j = m ? s ^ i[1:0] : s + i[1:0];
                        chk({qp, q} === mem[j] && q_oe === 1'b0, "read word");
                        @(negedge clk);
                    end
            end
        join
    endtask
    task t_rw;
        int l;
        for (l = 0; l < 4; l++)
            wr(0, l[1:0], 4'h0, word(l));
        rd(2'b10, 0, 4, 0);
        rd(2'b01, 1, 4, 0);
    endtask
    task t_lanes;
        wr(0, 2'b00, 4'b1010, 36'h5_a5a5_a5a5);
        wr(0, 2'b01, 4'hf, 36'h0);
        rd(2'b00, 0, 2, 0);
    endtask
    task t_burst_wr;
        wr(0, 2'b11, 4'h0, word(7));
        wr(1, 2'b00, 4'h0, word(8));
        wr(1, 2'b01, 4'b0110, word(9));
        wr(1, 2'b10, 4'h0, word(10));
        rd(2'b11, 0, 4, 0);
    endtask
    task t_dummy;
        int i;
        ds;
        i_ctrl.o_oe_n <= 1'b1;
        i_ctrl.beat(0, 1, 1, 0, 4'hf, BASE, 0);
        for (i = 0; i < 6; i++)
        begin
            i_ctrl.beat(1, 0, 1, 0, 4'hf, 0, 0);
            @(negedge clk);
            chk(q_oe === 1'b1 && p_oe === 1'b1, "dummy read drove bus");
        end
        ds;
        i_ctrl.o_oe_n <= 1'b0;
    endtask
    task t_sleep;
        ds;
        @(posedge clk) i_ctrl.o_zz <= 1'b1;
        wt(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        i_ctrl.o_zz <= 1'b0;
        wt(1'b1, 1'b0);
        repeat (2) ds;
        rd(2'b00, 1, 4, 0);
    endtask
    initial
    begin
        rst_n = 0;
        n_mismatch = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk(q_oe === 1'b1 && p_oe === 1'b1, "bus after reset");
        t_rw;
        t_lanes;
        t_burst_wr;
        t_dummy;
        rd(2'b00, 0, 3, 5);
        t_sleep;
        complete_run;
    end
endmodule
`default_nettype wire
